// ---- core/aod_map.vh ----
// record layout, field positions, reset values and timing counts
// assumes inclusion by the record block and the scaler
`ifndef AOD_MAP_VH
`define AOD_MAP_VH

`define AOD_CLK_MHZ          100
`define AOD_TICK_US          1
`define AOD_TICK_CYCLES      (`AOD_TICK_US * `AOD_CLK_MHZ)
// last divider count, one less than the cycles per tick
`define AOD_DIV_LAST         7'd99

`define AOD_REC_PARAM        8'h00
`define AOD_REC_DIAG         8'h01
`define AOD_REC_FMT0         8'h80
`define AOD_REC_FMT1         8'h81
`define AOD_DIAG_SHORT_LEN   5'd4
`define AOD_DIAG_LEN         5'd20

`define AOD_PB_RESERVED      5'd0
`define AOD_PB_SHORT_EN      5'd1
`define AOD_PB_FMT0          5'd2
`define AOD_PB_FMT1          5'd3

`define AOD_DB_MOD_ERR       5'd0
`define AOD_DB_MOD_INFO      5'd1
`define AOD_DB_RSVD_C        5'd2
`define AOD_DB_INT_ERR       5'd3
`define AOD_DB_CHAN_KIND     5'd4
`define AOD_DB_BITS_PER_CH   5'd5
`define AOD_DB_CHAN_COUNT    5'd6
`define AOD_DB_CHAN_SUMMARY  5'd7
`define AOD_DB_CH0_ERR       5'd8
`define AOD_DB_CH1_ERR       5'd9
`define AOD_DB_UNUSED_FIRST  5'd10
`define AOD_DB_UNUSED_LAST   5'd15
`define AOD_DB_TICKER        5'd16

`define AOD_RST_RESERVED     8'h00
`define AOD_RST_SHORT_EN     8'h00
`define AOD_RST_FMT          8'h10
`define AOD_FMT_STD          8'h10
`define AOD_FMT_BIN          8'h20
`define AOD_FMT_OFF          8'hFF

`define AOD_MOD_INFO         8'h15
`define AOD_CHAN_KIND        8'h73
`define AOD_BITS_PER_CH      8'h08
`define AOD_CHAN_COUNT       8'h02

`define AOD_ME_FAIL          0
`define AOD_ME_INTERNAL      1
`define AOD_ME_EXTERNAL      2
`define AOD_ME_CHANNEL       3
`define AOD_ME_AUX           4
`define AOD_ME_PARAM         7
`define AOD_IE_BUF_OVF       3
`define AOD_IE_COMM          4
`define AOD_CE_PARAM         0
`define AOD_CE_SHORT         3

`define AOD_STD_FULL         16'h6C00
`define AOD_STD_MAX          16'h7EFF
`define AOD_BIN_FULL         16'h4000
`define AOD_BIN_MAX          16'h5000
`define AOD_FULL_MV          14'd10000

`endif

// ---- core/aod_records.v ----
// parameter and diagnostic records of a two-channel 0..10 V output module
// assumes the backplane stack presents record accesses as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "aod_map.vh"
module aod_records (
	input  wire        clk,
	input  wire        reset,
	input  wire        rec_wr,
	input  wire        rec_rd,
	input  wire [7:0]  record_number,
	input  wire [4:0]  rec_byte,
	input  wire [7:0]  rec_wdata,
	output reg  [7:0]  rec_rdata_q,
	output reg         rec_rvalid_q,
	output reg         rec_err_q,
	input  wire [15:0] out_code0,
	input  wire [15:0] out_code1,
	input  wire [1:0]  short_seen,
	input  wire        module_fail,
	input  wire        internal_fault,
	input  wire        external_fault,
	input  wire        aux_supply_missing,
	input  wire        diag_buf_overflow,
	input  wire        comm_fault,
	output wire [13:0] chan0_mv,
	output wire [13:0] chan1_mv,
	output wire        chan0_active,
	output wire        chan1_active,
	output reg  [1:0]  chan_err_led_q,
	output reg         group_err_led_q
);
	reg  [7:0]  short_en_q;
	reg  [7:0]  fmt0_q;
	reg  [7:0]  fmt1_q;
	reg  [6:0]  div_q;
	reg  [31:0] ticker_q;
	wire [1:0]  fmt_ok;
	wire [1:0]  par_err;
	wire [1:0]  short_err;
	wire [7:0]  ch0_err;
	wire [7:0]  ch1_err;
	wire [7:0]  summary;
	wire [7:0]  mod_err;
	wire [7:0]  int_err;
	reg  [7:0]  diag_byte;
	reg  [4:0]  diag_len;
	reg         rd_ok;

	function fmt_valid;
		input [7:0] f;
		begin
			fmt_valid = (f == `AOD_FMT_STD) || (f == `AOD_FMT_BIN) || (f == `AOD_FMT_OFF);
		end
	endfunction

	assign fmt_ok = {fmt_valid(fmt1_q), fmt_valid(fmt0_q)};
	assign par_err = ~fmt_ok;
	assign short_err = short_seen & short_en_q[1:0];
	assign ch0_err = {4'h0, short_err[0], 2'b00, par_err[0]};
	assign ch1_err = {4'h0, short_err[1], 2'b00, par_err[1]};
	assign summary = {6'h00, |ch1_err, |ch0_err};
	assign mod_err = {|par_err, 2'b00, aux_supply_missing, |summary[1:0],
		external_fault, internal_fault, module_fail};
	assign int_err = {3'b000, comm_fault, diag_buf_overflow, 3'b000};

	// parameter record; reserved byte and reserved bits are not stored
	always @(posedge clk)
	begin
		if (reset)
		begin
			short_en_q <= `AOD_RST_SHORT_EN;
			fmt0_q <= `AOD_RST_FMT;
			fmt1_q <= `AOD_RST_FMT;
		end
		else if (rec_wr)
		begin
			if (record_number == `AOD_REC_PARAM)
			begin
				if (rec_byte == `AOD_PB_SHORT_EN)
					short_en_q <= {6'h00, rec_wdata[1:0]};
				if (rec_byte == `AOD_PB_FMT0)
					fmt0_q <= rec_wdata;
				if (rec_byte == `AOD_PB_FMT1)
					fmt1_q <= rec_wdata;
			end
			else if (record_number == `AOD_REC_FMT0 && rec_byte == 5'd0)
				fmt0_q <= rec_wdata;
			else if (record_number == `AOD_REC_FMT1 && rec_byte == 5'd0)
				fmt1_q <= rec_wdata;
		end
	end

	// microsecond ticker from a divide-by-100 enable
	always @(posedge clk)
	begin
		if (reset)
		begin
			div_q <= 7'h00;
			ticker_q <= 32'h00000000;
		end
		else if (div_q == `AOD_DIV_LAST)
		begin
			div_q <= 7'h00;
			ticker_q <= ticker_q + 32'h00000001;
		end
		else
			div_q <= div_q + 7'h01;
	end

	always @*
	begin
		diag_byte = 8'h00;
		case (rec_byte)
			`AOD_DB_MOD_ERR:      diag_byte = mod_err;
			`AOD_DB_MOD_INFO:     diag_byte = `AOD_MOD_INFO;
			`AOD_DB_INT_ERR:      diag_byte = int_err;
			`AOD_DB_CHAN_KIND:    diag_byte = `AOD_CHAN_KIND;
			`AOD_DB_BITS_PER_CH:  diag_byte = `AOD_BITS_PER_CH;
			`AOD_DB_CHAN_COUNT:   diag_byte = `AOD_CHAN_COUNT;
			`AOD_DB_CHAN_SUMMARY: diag_byte = summary;
			`AOD_DB_CH0_ERR:      diag_byte = ch0_err;
			`AOD_DB_CH1_ERR:      diag_byte = ch1_err;
			5'd16:                diag_byte = ticker_q[7:0];
			5'd17:                diag_byte = ticker_q[15:8];
			5'd18:                diag_byte = ticker_q[23:16];
			5'd19:                diag_byte = ticker_q[31:24];
			default:              diag_byte = 8'h00;
		endcase
	end

	// record 00h reads the short diagnostic view, 01h the whole record
	always @*
	begin
		diag_len = 5'd0;
		if (record_number == `AOD_REC_PARAM)
			diag_len = `AOD_DIAG_SHORT_LEN;
		else if (record_number == `AOD_REC_DIAG)
			diag_len = `AOD_DIAG_LEN;
		rd_ok = rec_byte < diag_len;
	end

	// answers only on a read; nothing is pushed to the host
	always @(posedge clk)
	begin
		if (reset)
		begin
			rec_rdata_q <= 8'h00;
			rec_rvalid_q <= 1'b0;
			rec_err_q <= 1'b0;
		end
		else
		begin
			rec_rvalid_q <= rec_rd && rd_ok;
			rec_err_q <= rec_rd && !rd_ok;
			rec_rdata_q <= (rec_rd && rd_ok) ? diag_byte : 8'h00;
		end
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			chan_err_led_q <= 2'b00;
			group_err_led_q <= 1'b0;
		end
		else
		begin
			chan_err_led_q <= summary[1:0];
			group_err_led_q <= |mod_err;
		end
	end

	aod_scale u_scale0 (
		.clk      (clk),
		.reset    (reset),
		.code     (out_code0),
		.fmt      (fmt0_q),
		.fmt_ok   (fmt_ok[0]),
		.mv_q     (chan0_mv),
		.active_q (chan0_active)
	);

	aod_scale u_scale1 (
		.clk      (clk),
		.reset    (reset),
		.code     (out_code1),
		.fmt      (fmt1_q),
		.fmt_ok   (fmt_ok[1]),
		.mv_q     (chan1_mv),
		.active_q (chan1_active)
	);
endmodule // aod_records
`default_nettype wire

// ---- core/aod_scale.v ----
// one channel: output code to output voltage in millivolts
// assumes the format code has been checked by the record block
`timescale 1ns/1ps
`default_nettype none
`include "aod_map.vh"
module aod_scale (
	input  wire        clk,
	input  wire        reset,
	input  wire [15:0] code,
	input  wire [7:0]  fmt,
	input  wire        fmt_ok,
	output reg  [13:0] mv_q,
	output reg         active_q
);
	reg  [15:0] lim;
	reg  [29:0] prod;
	reg  [29:0] quo;
	reg  [13:0] mv_d;

	always @*
	begin
		lim = 16'h0000;
		prod = 30'h00000000;
		quo = 30'h00000000;
		mv_d = 14'h0000;
		if (!code[15])
		begin
			if (fmt == `AOD_FMT_BIN)
			begin
				lim = (code > `AOD_BIN_MAX) ? `AOD_BIN_MAX : code;
				prod = lim * `AOD_FULL_MV;
				mv_d = prod[27:14];
			end
			else
			begin
				lim = (code > `AOD_STD_MAX) ? `AOD_STD_MAX : code;
				prod = lim * `AOD_FULL_MV;
				quo = prod / `AOD_STD_FULL;
				mv_d = quo[13:0];
			end
		end
		// negative codes leave mv_d at zero
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			mv_q <= 14'h0000;
			active_q <= 1'b0;
		end
		else
		begin
			// a deactivated or badly set channel is held at 0 V
			active_q <= fmt_ok && (fmt != `AOD_FMT_OFF);
			mv_q <= (fmt_ok && (fmt != `AOD_FMT_OFF)) ? mv_d : 14'h0000;
		end
	end
endmodule // aod_scale
`default_nettype wire

// ---- tb/analog_out_param_diag_records_tb.sv ----
// self-checking bench for the record block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module analog_out_param_diag_records_tb;
	logic        clk = 1'b0, reset = 1'b1;
	logic        rec_wr, rec_rd, rec_rvalid_q, rec_err_q, chan0_active, chan1_active;
	logic [7:0]  record_number, rec_wdata, rec_rdata_q;
	logic [4:0]  rec_byte;
	logic [15:0] out_code0 = 16'h0000, out_code1 = 16'h0000;
	logic [1:0]  short_seen = 2'h0, chan_err_led_q;
	logic        module_fail = 1'b0, internal_fault = 1'b0, external_fault = 1'b0;
	logic        aux_supply_missing = 1'b0, diag_buf_overflow = 1'b0, comm_fault = 1'b0;
	logic [13:0] chan0_mv, chan1_mv;
	logic        group_err_led_q;
	int          fails = 0, cmp_count = 0, cyc = 0;
	aod_records u_dut (.*);
	aod_host u_host (.*);
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		// generous: the sequence needs a few hundred cycles
		if (cyc == 3000)
		begin
			fails++;
			results;
		end
	end
	task results;
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] rn, input logic [4:0] b, input logic [7:0] d);
		u_host.acc(1'b1, rn, b, d);
	endtask
	task rd(input logic [7:0] rn, input logic [4:0] b, input logic [9:0] exp);
		u_host.acc(1'b0, rn, b, 8'h00);
		#1 chk({6'h00, rec_err_q, rec_rvalid_q, rec_rdata_q}, {6'h00, exp});
	endtask
	task t_tick;
		logic [7:0] v;
		u_host.acc(1'b0, 8'h01, 5'h10, 8'h00);
		#1 v = rec_rdata_q;
		repeat (200) @(posedge clk);
		u_host.acc(1'b0, 8'h01, 5'h10, 8'h00);
		#1 chk({15'h0000, (rec_rdata_q - v == 8'h02) || (rec_rdata_q - v == 8'h03)}, 16'h0001);
	endtask
	task sc(input logic [15:0] c0, input logic [15:0] c1, input logic [13:0] e0, input logic [13:0] e1);
		@(posedge clk);
		out_code0 <= c0;
		out_code1 <= c1;
		@(posedge clk);
		#1 chk({chan0_mv, 2'h0}, {e0, 2'h0});
		chk({chan1_mv, 2'h0}, {e1, 2'h0});
	endtask
	task t_ids;
		rd(8'h01, 5'h01, 10'h115);
		rd(8'h01, 5'h04, 10'h173);
		rd(8'h01, 5'h05, 10'h108);
		rd(8'h01, 5'h06, 10'h102);
		rd(8'h01, 5'h02, 10'h100);
		rd(8'h01, 5'h0F, 10'h100);
		rd(8'h00, 5'h03, 10'h100);
		rd(8'h01, 5'h14, 10'h200);
		rd(8'h00, 5'h04, 10'h200);
		rd(8'h02, 5'h00, 10'h200);
	endtask
	task t_scale;
		sc(16'h6C00, 16'h3600, 14'h2710, 14'h1388);
		sc(16'h7EFF, 16'h7FFF, 14'h2DEE, 14'h2DEE);
		sc(16'h8000, 16'hFFFF, 14'h0000, 14'h0000);
		wr(8'h00, 5'h02, 8'h20);
		wr(8'h81, 5'h00, 8'h20);
		sc(16'h4000, 16'h5000, 14'h2710, 14'h30D4);
		sc(16'h7FFF, 16'h2000, 14'h30D4, 14'h1388);
		wr(8'h00, 5'h02, 8'h10);
		wr(8'h00, 5'h03, 8'h10);
		sc(16'h6C00, 16'h6C00, 14'h2710, 14'h2710);
	endtask
	task t_off;
		wr(8'h81, 5'h00, 8'hFF);
		@(posedge clk);
		#1 chk({chan1_active, chan0_active, chan1_mv}, 16'h4000);
		wr(8'h81, 5'h00, 8'h10);
	endtask
	task t_err;
		wr(8'h80, 5'h00, 8'h33);
		rd(8'h01, 5'h00, 10'h188);
		rd(8'h01, 5'h07, 10'h101);
		rd(8'h01, 5'h08, 10'h101);
		chk({14'h0000, chan_err_led_q}, 16'h0001);
		chk({15'h0000, group_err_led_q}, 16'h0001);
		wr(8'h80, 5'h00, 8'h10);
		short_seen <= 2'h2;
		rd(8'h01, 5'h09, 10'h100);
		wr(8'h00, 5'h01, 8'h02);
		rd(8'h01, 5'h09, 10'h108);
		rd(8'h01, 5'h07, 10'h102);
		short_seen <= 2'h0;
		{module_fail, internal_fault, external_fault} <= 3'h7;
		{aux_supply_missing, diag_buf_overflow, comm_fault} <= 3'h7;
		rd(8'h01, 5'h00, 10'h117);
		rd(8'h00, 5'h03, 10'h118);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_ids;
		t_scale;
		t_off;
		t_err;
		t_tick;
		results;
	end
endmodule // analog_out_param_diag_records_tb
`default_nettype wire

// ---- tb/aod_chk.sv ----
// port checker for the record block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module aod_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        rec_wr,
	input wire logic        rec_rd,
	input wire logic [7:0]  record_number,
	input wire logic [4:0]  rec_byte,
	input wire logic [7:0]  rec_wdata,
	input wire logic [7:0]  rec_rdata_q,
	input wire logic        rec_rvalid_q,
	input wire logic        rec_err_q,
	input wire logic [15:0] out_code0,
	input wire logic        diag_buf_overflow,
	input wire logic        comm_fault,
	input wire logic [13:0] chan0_mv,
	input wire logic        chan1_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence diag_rd(int b);
		rec_rd && record_number == 8'h01 && rec_byte == b;
	endsequence
	sequence off1_wr;
		rec_wr && record_number == 8'h81 && rec_byte == 5'h00 && rec_wdata == 8'hFF;
	endsequence
	rd_answer_a: assert property (rec_rd |=> rec_rvalid_q ^ rec_err_q)
		else $error("read got no single answer");
	no_push_a: assert property (!rec_rd |=> !rec_rvalid_q && !rec_err_q)
		else $error("answer without read");
	diag_len_a: assert property (rec_rd && record_number == 8'h01 && rec_byte > 5'h13 |=> rec_err_q)
		else $error("read past record end accepted");
	kind_byte_a: assert property (diag_rd(4) |=> rec_rdata_q == 8'h73)
		else $error("channel kind byte wrong");
	info_byte_a: assert property (diag_rd(1) |=> rec_rdata_q == 8'h15)
		else $error("module info byte wrong");
	count_byte_a: assert property (diag_rd(6) |=> rec_rdata_q == 8'h02)
		else $error("channel count byte wrong");
	rsvd_zero_a: assert property (diag_rd(12) |=> rec_rdata_q == 8'h00)
		else $error("reserved byte not zero");
	int_err_a: assert property (diag_rd(3) |=> rec_rdata_q == {3'h0, $past(comm_fault), $past(diag_buf_overflow), 3'h0})
		else $error("internal error byte wrong");
	neg_zero_a: assert property ($signed(out_code0) < 0 |=> chan0_mv == 14'h0000)
		else $error("negative code gave output");
	chan_off_a: assert property (off1_wr ##1 !rec_wr |=> !chan1_active)
		else $error("channel stayed on");
endmodule // aod_chk
bind aod_records aod_chk u_chk (.*);
`default_nettype wire

// ---- tb/aod_host.sv ----
// host model issuing record reads and writes
// assumes one-cycle strobes, read answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module aod_host (
	input  wire logic       clk,
	output var  logic       rec_wr,
	output var  logic       rec_rd,
	output var  logic [7:0] record_number,
	output var  logic [4:0] rec_byte,
	output var  logic [7:0] rec_wdata
);
	initial
	begin
		{rec_wr, rec_rd, record_number, rec_byte, rec_wdata} = 23'h000000;
	end
	task acc(input logic w, input logic [7:0] rn, input logic [4:0] b, input logic [7:0] d);
		@(posedge clk);
		rec_wr <= w;
		rec_rd <= !w;
		record_number <= rn;
		rec_byte <= b;
		rec_wdata <= d;
		@(posedge clk);
		rec_wr <= 1'b0;
		rec_rd <= 1'b0;
		// released lines carry no stale value
		record_number <= ~rn;
		rec_byte <= ~b;
		rec_wdata <= ~d;
	endtask
endmodule // aod_host
`default_nettype wire
